/* File: pwmga_pkg.sv */
package pwmga_pkg;

   localparam int NGEN = 4;
   localparam int NOUT = 8;
   localparam int CW = 16;

   // Byte offsets of the register map.
   localparam logic [7:0] OFF_CTL = 8'h00;
   localparam logic [7:0] OFF_SYNC = 8'h04;
   localparam logic [7:0] OFF_OUTEN = 8'h08;
   localparam logic [7:0] OFF_INV = 8'h0C;
   localparam logic [7:0] OFF_FSEL = 8'h10;
   localparam logic [7:0] OFF_ISTAT = 8'h14;
   localparam logic [7:0] OFF_IMASK = 8'h18;
   localparam logic [7:0] OFF_LCLR = 8'h1C;
   localparam logic [7:0] OFF_GEN_BASE = 8'h20;
   localparam logic [7:0] OFF_CNT_BASE = 8'h60;
   localparam logic [7:0] OFF_END = 8'h70;

   // Word index inside one generator's four-word group.
   localparam logic [1:0] SUB_LOAD = 2'h0;
   localparam logic [1:0] SUB_CMPA = 2'h1;
   localparam logic [1:0] SUB_CMPB = 2'h2;
   localparam logic [1:0] SUB_DB = 2'h3;

   // Field positions.
   localparam int CTL_EN_POS = 0;
   localparam int CTL_DB_POS = 4;
   localparam int CTL_UD_POS = 8;
   localparam int CTL_SY_POS = 12;
   localparam int CTL_EXT_POS = 16;
   localparam int DB_RISE_POS = 0;
   localparam int DB_FALL_POS = 16;
   localparam int ISTAT_GEN_POS = 4;

   // Reset values.
   localparam logic [3:0] NIB_RST = 4'h0;
   localparam logic [7:0] OUTEN_RST = 8'h00;
   localparam logic [7:0] INV_RST = 8'h00;
   localparam logic [15:0] FSEL_RST = 16'h0000;
   localparam logic [7:0] STAT_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [15:0] VAL_RST = 16'h0000;

   typedef enum logic {PWMGA_UP, PWMGA_DOWN} pwmga_dir_type;

endpackage

/* File: pwmga_gen.sv */
`timescale 1ns/1ns
module pwmga_gen (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic updown,
   input wire logic sync_mode,
   input wire logic db_en,
   input wire logic sync_evt,
   input wire logic [15:0] load_in,
   input wire logic [15:0] cmpa_in,
   input wire logic [15:0] cmpb_in,
   input wire logic [15:0] rise_in,
   input wire logic [15:0] fall_in,
   output logic first_channel_output,
   output logic second_channel_output,
   output logic [15:0] count,
   output logic zero_evt
);
   logic [15:0] load_q, cmpa_q, cmpb_q, cnt_q, cnt_d, rise_cnt_q, fall_cnt_q;
   logic sync_pend_q, wave_a_q, wave_b_q;
   pwmga_pkg::pwmga_dir_type dir_q, dir_d;
   wire at_zero = (cnt_q == 16'h0000);
   wire do_upd = at_zero && (!sync_mode || sync_pend_q); // RQ16
   wire [15:0] load_eff = do_upd ? load_in : load_q;

   always_comb begin
      cnt_d = cnt_q;
      dir_d = dir_q;
      if (en) begin // RQ17
         if (!updown) begin // RQ15
            dir_d = pwmga_pkg::PWMGA_DOWN;
            cnt_d = at_zero ? load_eff : cnt_q - 16'h0001;
         end else begin
            case (dir_q)
               pwmga_pkg::PWMGA_UP: begin // RQ15
                  if (cnt_q >= load_eff) begin
                     dir_d = pwmga_pkg::PWMGA_DOWN;
                     cnt_d = at_zero ? cnt_q : cnt_q - 16'h0001;
                  end else begin
                     cnt_d = cnt_q + 16'h0001;
                  end
               end
               pwmga_pkg::PWMGA_DOWN: begin
                  if (at_zero) begin
                     dir_d = pwmga_pkg::PWMGA_UP;
                     cnt_d = (load_eff != 16'h0000) ? 16'h0001 : 16'h0000;
                  end else begin
                     cnt_d = cnt_q - 16'h0001;
                  end
               end
               default: begin
                  dir_d = pwmga_pkg::PWMGA_UP;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= pwmga_pkg::VAL_RST;
         dir_q <= pwmga_pkg::PWMGA_UP;
         load_q <= pwmga_pkg::VAL_RST;
         cmpa_q <= pwmga_pkg::VAL_RST;
         cmpb_q <= pwmga_pkg::VAL_RST;
         sync_pend_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         dir_q <= dir_d;
         sync_pend_q <= sync_evt | (sync_pend_q & !do_upd); // RQ16
         if (do_upd) begin // RQ16
            load_q <= load_in;
            cmpa_q <= cmpa_in;
            cmpb_q <= cmpb_in;
         end
      end
   end

   // Waveform and dead-band delay counters; delays count module clock ticks.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wave_a_q <= 1'b0;
         wave_b_q <= 1'b0;
         rise_cnt_q <= pwmga_pkg::VAL_RST;
         fall_cnt_q <= pwmga_pkg::VAL_RST;
      end else begin
         wave_a_q <= (cnt_q > cmpa_q); // RQ6 RQ18
         wave_b_q <= (cnt_q > cmpb_q); // RQ6 RQ18
         rise_cnt_q <= !wave_a_q ? 16'h0000 :
                       (rise_cnt_q == 16'hFFFF) ? rise_cnt_q : rise_cnt_q + 16'h0001; // RQ8
         fall_cnt_q <= wave_a_q ? 16'h0000 :
                       (fall_cnt_q == 16'hFFFF) ? fall_cnt_q : fall_cnt_q + 16'h0001; // RQ8
      end
   end

   assign first_channel_output = db_en ? (wave_a_q && rise_cnt_q >= rise_in) : wave_a_q; // RQ19
   assign second_channel_output = db_en ? (!wave_a_q && fall_cnt_q >= fall_in) : wave_b_q; // RQ7 RQ19
   assign count = cnt_q;
   assign zero_evt = en && at_zero;
endmodule

/* File: pwmga_top.sv */
// The address map and register access over APB were decided locally.
`timescale 1ns/1ns
// What this block does
// RQ1: Four generators, each with a 16-bit down or up/down counter and two comparators.
// RQ2: Each generator drives two outputs, independent or complementary with dead band.
// RQ3: Each generator has its own interrupt output and trigger output.
// RQ4: Control sets each output's polarity and whether it reaches its pin.
// RQ5: Outputs 2g and 2g+1 belong to generator g.
// RQ6: Comparator A sets the even output's width, comparator B the odd one.
// RQ7: Dead band off makes the second output independent of the first.
// RQ8: Dead band on derives the second output; delays count clock ticks from edges.
// RQ9: Writing a one to a fault status bit clears that fault interrupt.
// RQ10: Four fault flags, clearable singly or together in one write.
// RQ11: The legacy clear touches only fault flag 0.
// RQ12: Extended mode: fault flag is OR of that generator's selected fault inputs.
// RQ13: Legacy mode: the fault flag follows the single external fault input.
// RQ14: Software should clear the fault early in its handler.
// RQ15: Down mode reloads at zero; up/down mode ramps zero to load and back.
// RQ16: Load and compare updates apply at zero, after a sync event in sync mode.
// RQ17: A disabled generator's counter holds; generators reset disabled.
// RQ18: Outputs toggle at zero, reload and compare; high time tracks the compare.
// RQ19: Dead band: first output rise-delayed, second is inverse rise-delayed by fall count.
module pwmga_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] external_fault_input,
   output logic [7:0] pulse_output,
   output logic [3:0] gen_irq,
   output logic [3:0] gen_trig,
   output logic irq
);
   logic [3:0] gen_en_q, db_en_q, updown_q, sync_mode_q, sync_evt_q;
   logic ext_fault_q;
   logic [7:0] out_en_q, inv_q, stat_q, mask_q, pulse_q;
   logic [15:0] fsel_q;
   logic [15:0] load_q [4];
   logic [15:0] cmpa_q [4];
   logic [15:0] cmpb_q [4];
   logic [15:0] rise_q [4];
   logic [15:0] fall_q [4];
   logic [3:0] fault_m_q, fault_s_q, gen_irq_q, gen_trig_q;
   logic [31:0] prdata_q, rd_d;
   logic pready_q, pslverr_q, irq_q;
   logic [3:0] ga, gb, zero_evt, fsrc;
   logic [15:0] gcnt [4];
   logic [7:0] wave, fgate;

   function automatic logic [1:0] gen_index(input logic [7:0] a);
      gen_index = 2'((a - pwmga_pkg::OFF_GEN_BASE) >> 4);
   endfunction

   // Address decode.
   wire aligned = (paddr[1:0] == 2'b00);
   wire hit_ctl = aligned && paddr == pwmga_pkg::OFF_CTL;
   wire hit_sync = aligned && paddr == pwmga_pkg::OFF_SYNC;
   wire hit_outen = aligned && paddr == pwmga_pkg::OFF_OUTEN;
   wire hit_inv = aligned && paddr == pwmga_pkg::OFF_INV;
   wire hit_fsel = aligned && paddr == pwmga_pkg::OFF_FSEL;
   wire hit_istat = aligned && paddr == pwmga_pkg::OFF_ISTAT;
   wire hit_imask = aligned && paddr == pwmga_pkg::OFF_IMASK;
   wire hit_lclr = aligned && paddr == pwmga_pkg::OFF_LCLR;
   wire hit_gen = aligned && paddr >= pwmga_pkg::OFF_GEN_BASE && paddr < pwmga_pkg::OFF_CNT_BASE;
   wire hit_cnt = aligned && paddr >= pwmga_pkg::OFF_CNT_BASE && paddr < pwmga_pkg::OFF_END;
   wire mapped = hit_ctl | hit_sync | hit_outen | hit_inv | hit_fsel | hit_istat |
                 hit_imask | hit_lclr | hit_gen | hit_cnt;
   wire [1:0] gidx = gen_index(paddr);
   wire [1:0] cidx = paddr[3:2];
   wire [1:0] sub = paddr[3:2];
   wire setup = psel && !penable;
   wire wr = psel && penable && pready_q && pwrite && mapped;

   // Read data multiplexer.
   always_comb begin
      rd_d = 32'h0000_0000;
      if (hit_ctl) begin
         rd_d = {15'h0000, ext_fault_q, sync_mode_q, updown_q, db_en_q, gen_en_q};
      end else if (hit_outen) begin
         rd_d = {24'h00_0000, out_en_q};
      end else if (hit_inv) begin
         rd_d = {24'h00_0000, inv_q};
      end else if (hit_fsel) begin
         rd_d = {16'h0000, fsel_q};
      end else if (hit_istat) begin
         rd_d = {24'h00_0000, stat_q};
      end else if (hit_imask) begin
         rd_d = {24'h00_0000, mask_q};
      end else if (hit_cnt) begin
         rd_d = {16'h0000, gcnt[cidx]};
      end else if (hit_gen) begin
         case (sub)
            pwmga_pkg::SUB_LOAD: rd_d = {16'h0000, load_q[gidx]};
            pwmga_pkg::SUB_CMPA: rd_d = {16'h0000, cmpa_q[gidx]};
            pwmga_pkg::SUB_CMPB: rd_d = {16'h0000, cmpb_q[gidx]};
            default: rd_d = {fall_q[gidx], rise_q[gidx]};
         endcase
      end
   end

   // APB answer: data and status registered in the setup cycle, zero wait states.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup && !mapped;
         prdata_q <= (setup && !pwrite) ? rd_d : 32'h0000_0000;
      end
   end

   // Control registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gen_en_q <= pwmga_pkg::NIB_RST; // RQ17
         db_en_q <= pwmga_pkg::NIB_RST;
         updown_q <= pwmga_pkg::NIB_RST;
         sync_mode_q <= pwmga_pkg::NIB_RST;
         ext_fault_q <= 1'b0;
         out_en_q <= pwmga_pkg::OUTEN_RST;
         inv_q <= pwmga_pkg::INV_RST;
         fsel_q <= pwmga_pkg::FSEL_RST;
         mask_q <= pwmga_pkg::MASK_RST;
         sync_evt_q <= pwmga_pkg::NIB_RST;
      end else begin
         sync_evt_q <= (wr && hit_sync) ? pwdata[3:0] : 4'h0; // RQ16
         if (wr && hit_ctl) begin
            gen_en_q <= pwdata[pwmga_pkg::CTL_EN_POS +: 4]; // RQ17
            db_en_q <= pwdata[pwmga_pkg::CTL_DB_POS +: 4];
            updown_q <= pwdata[pwmga_pkg::CTL_UD_POS +: 4];
            sync_mode_q <= pwdata[pwmga_pkg::CTL_SY_POS +: 4];
            ext_fault_q <= pwdata[pwmga_pkg::CTL_EXT_POS];
         end
         if (wr && hit_outen) out_en_q <= pwdata[7:0]; // RQ4
         if (wr && hit_inv) inv_q <= pwdata[7:0]; // RQ4
         if (wr && hit_fsel) fsel_q <= pwdata[15:0];
         if (wr && hit_imask) mask_q <= pwdata[7:0];
      end
   end

   // Per-generator parameter registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int g = 0; g < pwmga_pkg::NGEN; g++) begin
            load_q[g] <= pwmga_pkg::VAL_RST;
            cmpa_q[g] <= pwmga_pkg::VAL_RST;
            cmpb_q[g] <= pwmga_pkg::VAL_RST;
            rise_q[g] <= pwmga_pkg::VAL_RST;
            fall_q[g] <= pwmga_pkg::VAL_RST;
         end
      end else if (wr && hit_gen) begin
         case (sub)
            pwmga_pkg::SUB_LOAD: load_q[gidx] <= pwdata[15:0];
            pwmga_pkg::SUB_CMPA: cmpa_q[gidx] <= pwdata[15:0];
            pwmga_pkg::SUB_CMPB: cmpb_q[gidx] <= pwdata[15:0];
            default: begin
               rise_q[gidx] <= pwdata[pwmga_pkg::DB_RISE_POS +: 16];
               fall_q[gidx] <= pwdata[pwmga_pkg::DB_FALL_POS +: 16];
            end
         endcase
      end
   end

   // Fault input synchroniser.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_m_q <= 4'h0;
         fault_s_q <= 4'h0;
      end else begin
         fault_m_q <= external_fault_input;
         fault_s_q <= fault_m_q;
      end
   end

   for (genvar g = 0; g < pwmga_pkg::NGEN; g++) begin : gens
      pwmga_gen u_gen ( // RQ1 RQ2
         .clk(pclk),
         .rst_n(presetn),
         .en(gen_en_q[g]),
         .updown(updown_q[g]),
         .sync_mode(sync_mode_q[g]),
         .db_en(db_en_q[g]),
         .sync_evt(sync_evt_q[g]),
         .load_in(load_q[g]),
         .cmpa_in(cmpa_q[g]),
         .cmpb_in(cmpb_q[g]),
         .rise_in(rise_q[g]),
         .fall_in(fall_q[g]),
         .first_channel_output(ga[g]),
         .second_channel_output(gb[g]),
         .count(gcnt[g]),
         .zero_evt(zero_evt[g])
      );
      if (g == 0) begin : legacy
         assign fsrc[g] = ext_fault_q ? |(fault_s_q & fsel_q[4*g +: 4]) : fault_s_q[0]; // RQ12 RQ13
      end else begin : extonly
         assign fsrc[g] = ext_fault_q && |(fault_s_q & fsel_q[4*g +: 4]); // RQ12
      end
      assign wave[2*g] = ga[g]; // RQ5
      assign wave[2*g+1] = gb[g]; // RQ5
      assign fgate[2*g] = fsrc[g];
      assign fgate[2*g+1] = fsrc[g];
   end

   // Interrupt status: sources set, write-one clears, set wins over clear.
   wire [7:0] clr_vec = ((wr && hit_istat) ? pwdata[7:0] : 8'h00) | // RQ9 RQ10
                        ((wr && hit_lclr) ? 8'h01 : 8'h00); // RQ11
   wire [7:0] set_vec = {zero_evt, fsrc};
   wire [7:0] stat_d = (stat_q & ~clr_vec) | set_vec;
   wire [7:0] pulse_d = out_en_q & ~fgate & (wave ^ inv_q); // RQ4

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= pwmga_pkg::STAT_RST;
         pulse_q <= 8'h00;
         irq_q <= 1'b0;
         gen_irq_q <= 4'h0;
         gen_trig_q <= 4'h0;
      end else begin
         stat_q <= stat_d; // RQ9 RQ10
         pulse_q <= pulse_d;
         irq_q <= |(stat_q & mask_q);
         gen_irq_q <= stat_q[pwmga_pkg::ISTAT_GEN_POS +: 4] &
                      mask_q[pwmga_pkg::ISTAT_GEN_POS +: 4]; // RQ3
         gen_trig_q <= zero_evt; // RQ3
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign pulse_output = pulse_q;
   assign gen_irq = gen_irq_q;
   assign gen_trig = gen_trig_q;
   assign irq = irq_q;

   a_w1c_clears_flag: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
      (wr && hit_istat && pwdata[0] && !fsrc[0]) |=> !stat_q[0])
      else $error("fault flag 0 not cleared by write one");
   a_multi_clear: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
      (wr && hit_istat && pwdata[3:0] == 4'hF && fsrc == 4'h0) |=> stat_q[3:0] == 4'h0)
      else $error("fault flags not cleared together");
   a_legacy_only0: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
      (wr && hit_lclr) |=> stat_q[3:1] == $past(stat_q[3:1] | fsrc[3:1]))
      else $error("legacy clear touched flags 1 to 3");
   a_ext_fault_or: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
      (ext_fault_q && |(fault_s_q & fsel_q[7:4])) |=> stat_q[1])
      else $error("selected fault did not set flag 1");
   a_legacy_fault_pin: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
      (!ext_fault_q && fault_s_q[0]) |=> (stat_q[0] && !pulse_q[0] && !pulse_q[1]))
      else $error("fault pin did not set flag or gate outputs");
   a_out_gating: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
      (out_en_q == 8'h00) |=> pulse_output == 8'h00)
      else $error("disabled outputs reached pins");
   a_pair_map: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
      (out_en_q == 8'hFF && inv_q == 8'h00 && fsrc == 4'h0)
      |=> pulse_output == $past({gb[3], ga[3], gb[2], ga[2], gb[1], ga[1], gb[0], ga[0]}))
      else $error("output pair mapping wrong");
   a_gen_hold: assert property (@(posedge pclk) disable iff (!presetn) // RQ17
      !gen_en_q[0] |=> gcnt[0] == $past(gcnt[0]))
      else $error("disabled counter moved");
   a_db_exclusive: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
      db_en_q[0] |-> !(ga[0] && gb[0]))
      else $error("dead band outputs overlap");
endmodule

/* File: pwmga_load.sv */
`timescale 1ns/1ns
// Power stage model: it senses conducting time of the first two legs only and reports overcurrent on fault lines.
module pwmga_load (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] pulse_output,
   input wire logic clr,
   input wire logic [3:0] fault_cmd,
   output logic [3:0] external_fault_input,
   output logic [15:0] hi0_q,
   output logic [15:0] hi1_q
);
   // Conducting cycles of the two legs of the first half bridge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi0_q <= 16'h0000;
         hi1_q <= 16'h0000;
      end else if (clr) begin
         hi0_q <= 16'h0000;
         hi1_q <= 16'h0000;
      end else begin
         hi0_q <= hi0_q + {15'h0000, pulse_output[0]};
         hi1_q <= hi1_q + {15'h0000, pulse_output[1]};
      end
   end

   // Overcurrent reports leave the stage one cycle after they are commanded.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         external_fault_input <= 4'h0;
      end else begin
         external_fault_input <= fault_cmd;
      end
   end
endmodule

/* File: test_pwm_generator_array.sv */
`timescale 1ns/1ns
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; $display("BAD t=%0t got %0h exp %0h", $time, (got), (exp)); end end
module test_pwm_generator_array;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [3:0] fin;
   logic [7:0] pout;
   logic [3:0] gen_irq;
   logic [3:0] gen_trig;
   logic irq;
   logic clr = 1'b0;
   logic [3:0] fault_cmd = 4'h0;
   logic [15:0] hi0;
   logic [15:0] hi1;
   logic [15:0] trig_n = 16'h0000;
   logic [31:0] rd;
   logic [31:0] cnt_v;
   logic er;
   logic [7:0] regs [8] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h60};
   int n_errors = 0;
   int samples_checked = 0;

   always #5 pclk = ~pclk;

   pwmga_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .external_fault_input(fin), .pulse_output(pout),
      .gen_irq(gen_irq), .gen_trig(gen_trig), .irq(irq));

   pwmga_load u_load (.pclk(pclk), .presetn(presetn), .pulse_output(pout), .clr(clr),
      .fault_cmd(fault_cmd), .external_fault_input(fin), .hi0_q(hi0), .hi1_q(hi1));

   // Trigger pulses of the first generator over the measuring window.
   always @(posedge pclk) begin
      if (clr) begin
         trig_n <= 16'h0000;
      end else begin
         trig_n <= trig_n + {15'h0000, gen_trig[0]};
      end
   end

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h00000000);
      `CHK(rd, exp);
   endtask

   task automatic stat(input logic [3:0] exp);
      apb(8'h14, 1'b0, 32'h00000000);
      `CHK(rd[3:0], exp);
   endtask

   // Counts are sampled over exactly n clock edges.
   task automatic measure(input int n);
      @(posedge pclk);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      repeat (n + 1) @(posedge pclk);
   endtask

   task automatic tally_and_finish();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      tally_and_finish();
   end

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      foreach (regs[i]) rdchk(regs[i], 32'h00000000);
      apb(8'h70, 1'b0, 32'h00000000);
      `CHK(er, 1'b1);
      `CHK(rd, 32'h00000000);
      apb(8'h02, 1'b1, 32'hFFFFFFFF);
      `CHK(er, 1'b1);
      wr(8'h20, 32'h00000009);
      wr(8'h24, 32'h00000003);
      wr(8'h28, 32'h00000005);
      wr(8'h08, 32'h000000FF);
      wr(8'h18, 32'h00000010);
      wr(8'h00, 32'h00000001);
      repeat (20) @(posedge pclk);
      measure(100);
      `CHK(hi0, 16'h003C);
      `CHK(hi1, 16'h0028);
      `CHK(trig_n, 16'h000A);
      `CHK(gen_irq, 4'h1);
      `CHK(irq, 1'b1);
      wr(8'h0C, 32'h00000001);
      wr(8'h08, 32'h00000001);
      measure(100);
      `CHK(hi0, 16'h0028);
      `CHK(hi1, 16'h0000);
      wr(8'h0C, 32'h00000000);
      wr(8'h08, 32'h000000FF);
      wr(8'h2C, 32'h00010002);
      wr(8'h00, 32'h00000011);
      repeat (20) @(posedge pclk);
      measure(100);
      `CHK(hi0, 16'h0028);
      `CHK(hi1, 16'h001E);
      wr(8'h00, 32'h00000001);
      repeat (20) @(posedge pclk);
      measure(100);
      `CHK(hi0, 16'h003C);
      `CHK(hi1, 16'h0028);
      wr(8'h00, 32'h00000101);
      repeat (40) @(posedge pclk);
      measure(180);
      `CHK(hi0, 16'h006E);
      `CHK(hi1, 16'h0046);
      `CHK(trig_n, 16'h000A);
      wr(8'h00, 32'h00000000);
      apb(8'h60, 1'b0, 32'h00000000);
      cnt_v = rd;
      measure(50);
      `CHK(trig_n, 16'h0000);
      rdchk(8'h60, cnt_v);
      wr(8'h00, 32'h00001001);
      repeat (40) @(posedge pclk);
      wr(8'h24, 32'h00000007);
      measure(100);
      `CHK(hi0, 16'h003C);
      wr(8'h04, 32'h00000001);
      repeat (40) @(posedge pclk);
      measure(100);
      `CHK(hi0, 16'h0014);
      wr(8'h18, 32'h00000000);
      fault_cmd <= 4'h2;
      repeat (8) @(posedge pclk);
      stat(4'h0);
      fault_cmd <= 4'h1;
      repeat (8) @(posedge pclk);
      stat(4'h1);
      `CHK(irq, 1'b0);
      wr(8'h18, 32'h00000001);
      repeat (3) @(posedge pclk);
      `CHK(irq, 1'b1);
      fault_cmd <= 4'h0;
      repeat (8) @(posedge pclk);
      wr(8'h14, 32'h00000001);
      stat(4'h0);
      repeat (3) @(posedge pclk);
      `CHK(irq, 1'b0);
      wr(8'h10, 32'h00000012);
      wr(8'h00, 32'h00010001);
      fault_cmd <= 4'h1;
      repeat (8) @(posedge pclk);
      fault_cmd <= 4'h0;
      repeat (8) @(posedge pclk);
      stat(4'h2);
      wr(8'h14, 32'h0000000F);
      wr(8'h10, 32'h0000FFFF);
      fault_cmd <= 4'h8;
      repeat (8) @(posedge pclk);
      measure(20);
      `CHK(hi0, 16'h0000);
      `CHK(pout, 8'h00);
      fault_cmd <= 4'h0;
      repeat (8) @(posedge pclk);
      stat(4'hF);
      wr(8'h1C, 32'h00000000);
      stat(4'hE);
      wr(8'h14, 32'h00000006);
      stat(4'h8);
      wr(8'h14, 32'h00000008);
      stat(4'h0);
      tally_and_finish();
   end
endmodule
